// [logic/fwg_cpu.sv]
// Decided for this implementation: the address map and the strobed register port.
`timescale 1ns/1ps
module fwg_cpu (
    // clock and reset
    input  wire logic        i_core_clk,
    input  wire logic        i_rst_b,
    // software register port
    input  wire logic [3:0]  i_addr,
    input  wire logic [7:0]  i_wdata,
    input  wire logic        i_wr,
    input  wire logic        i_rd,
    output logic      [7:0]  o_rdata,
    // link
    fwg_if.cpu               bus
);
    typedef struct packed {
        logic [15:0] addr;
        logic [7:0]  data;
        logic        req;
        logic        we;
        logic        ram;
        logic        irq;
        logic        lp;
        logic [7:0]  last;
        logic [7:0]  rdata;
        logic        rd_pend;
    } fwg_cpu_state_t;

    fwg_cpu_state_t st_r;
    fwg_cpu_state_t st_nxt;

    always_comb begin
        st_nxt       = st_r;
        st_nxt.req   = 1'b0;
        st_nxt.irq   = 1'b0;
        st_nxt.rdata = 8'h00;
        if (st_r.rd_pend) begin
            st_nxt.last = bus.bus_rdata;
        end
        st_nxt.rd_pend = st_r.req && !st_r.we;
        if (i_wr) begin
            case (i_addr)
                fwg_pkg::H_ADDR_DATA: st_nxt.addr[15:8] = i_wdata;
                fwg_pkg::H_ADDR:      st_nxt.addr[7:0]  = i_wdata;
                fwg_pkg::H_DATA: begin
                    // bit three forced for control writes; code nibble used as given
                    if (st_r.addr == fwg_pkg::CMD_CTRL_ADDR) begin
                        st_nxt.data = i_wdata | 8'h08;
                    end else begin
                        st_nxt.data = i_wdata;
                    end
                end
                fwg_pkg::H_GO: begin
                    st_nxt.req = 1'b1;
                    st_nxt.we  = i_wdata[fwg_pkg::GO_WRITE_BIT];
                    st_nxt.ram = i_wdata[fwg_pkg::GO_FROM_RAM_BIT];
                    st_nxt.irq = i_wdata[fwg_pkg::GO_IRQ_BIT];
                end
                fwg_pkg::H_LOWPWR:    st_nxt.lp = i_wdata[0];
                default: ;
            endcase
        end
        if (i_rd) begin
            case (i_addr)
                fwg_pkg::H_ADDR_DATA: st_nxt.rdata = st_r.addr[15:8];
                fwg_pkg::H_ADDR:      st_nxt.rdata = st_r.addr[7:0];
                fwg_pkg::H_DATA:      st_nxt.rdata = st_r.last;
                fwg_pkg::H_STATUS:    st_nxt.rdata = {6'h00, bus.cmd_fire, bus.flash_stby};
                default:              st_nxt.rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_b) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign bus.bus_req   = st_r.req;
    assign bus.bus_we    = st_r.we;
    assign bus.bus_addr  = st_r.addr;
    assign bus.bus_wdata = st_r.data;
    assign bus.from_ram  = st_r.ram;
    assign bus.irq_take  = st_r.irq;
    assign bus.low_power = st_r.lp;
    assign o_rdata       = st_r.rdata;
endmodule

// [logic/fwg_pkg.sv]
package fwg_pkg;
    // cpu-side address map
    localparam logic [15:0] FLASH_BASE      = 16'hc000;
    localparam logic [15:0] FLASH_LAST      = 16'hffff;
    localparam int          FLASH_BYTES     = 16384;
    localparam logic [15:0] CMD_CTRL_ADDR   = 16'h0fe0;
    localparam logic [15:0] STBY_CTRL_ADDR  = 16'h0fe1;
    // flash_command_control layout
    localparam int          CODE_LSB        = 4;
    localparam int          MUST_ONE_BIT    = 3;
    localparam logic [3:0]  CODE_ENABLE     = 4'h3;
    localparam logic [3:0]  CODE_PROTECT    = 4'hc;
    localparam logic [3:0]  CODE_RESET      = 4'hc;
    // flash_standby_control layout
    localparam int          STBY_BIT        = 0;
    localparam logic        STBY_RESET      = 1'b0;
    // host register port map
    localparam logic [3:0]  H_ADDR_DATA     = 4'h0;
    localparam logic [3:0]  H_DATA          = 4'h1;
    localparam logic [3:0]  H_GO            = 4'h2;
    localparam logic [3:0]  H_STATUS        = 4'h3;
    localparam logic [3:0]  H_ADDR          = 4'h4;
    localparam logic [3:0]  H_LOWPWR        = 4'h5;
    localparam int          GO_WRITE_BIT    = 0;
    localparam int          GO_FROM_RAM_BIT = 1;
    localparam int          GO_IRQ_BIT      = 2;
endpackage

// [logic/fwg_if.sv]
`timescale 1ns/1ps
interface fwg_if;
    logic        bus_req;      // one-cycle access strobe
    logic        bus_we;
    logic [15:0] bus_addr;
    logic [7:0]  bus_wdata;
    logic        from_ram;     // access issued by code fetched from ram
    logic        irq_take;     // interrupt being taken
    logic        low_power;    // idle, sleep or stop mode level
    logic [7:0]  bus_rdata;
    logic        cmd_fire;     // accepted program/erase cycle
    logic        flash_stby;   // steady-state current cut
    modport dev  (input bus_req, bus_we, bus_addr, bus_wdata, from_ram, irq_take, low_power,
                  output bus_rdata, cmd_fire, flash_stby);
    modport cpu  (output bus_req, bus_we, bus_addr, bus_wdata, from_ram, irq_take, low_power,
                  input bus_rdata, cmd_fire, flash_stby);
endinterface

// [logic/fwg_decode.sv]
`timescale 1ns/1ps
module fwg_decode (
    // address in
    input  wire logic [15:0] i_addr,
    // decode out
    output logic             o_is_flash,
    output logic             o_is_cmd,
    output logic             o_is_stby
);
    always_comb begin
        o_is_flash = (i_addr >= fwg_pkg::FLASH_BASE) && (i_addr <= fwg_pkg::FLASH_LAST);
        o_is_cmd   = (i_addr == fwg_pkg::CMD_CTRL_ADDR);
        o_is_stby  = (i_addr == fwg_pkg::STBY_CTRL_ADDR);
    end
endmodule

// [logic/fwg_device.sv]
`timescale 1ns/1ps
// Overview of operation
// - program/erase accepted only with enable code
// - protect code blocks all command sequences
// - reset loads protect code
// - software writes only enable or protect
// - low four control bits read undefined
// - software always writes bit three one
// - keep protect code except when writing
// - low-power modes always cut flash current
// - ram code setting standby bit cuts current
// - standby set from flash code ignored
// - flash access clears standby bit
// - interrupt clears standby bit first
// - low-power entry clears standby bit
// - standby sequence runs from ram, interrupts off
// - ram code clears standby before returning
// - flash spans c000 to ffff
module fwg_device (
    // clock and reset
    input  wire logic i_core_clk,
    input  wire logic i_rst_b,
    // cpu link
    fwg_if.dev        bus,
    // flash array side
    output logic      o_cmd_enabled,
    output logic      o_array_powered
);
    typedef struct packed {
        logic [3:0] code;
        logic       stby;
        logic [7:0] rdata;
    } fwg_dev_state_t;

    fwg_dev_state_t st_r;
    fwg_dev_state_t st_nxt;
    logic           is_flash;
    logic           is_cmd;
    logic           is_stby;
    logic           cmd_en;

    fwg_decode u_dec (
        .i_addr     (bus.bus_addr),
        .o_is_flash (is_flash),
        .o_is_cmd   (is_cmd),
        .o_is_stby  (is_stby)
    );

    assign cmd_en = (st_r.code == fwg_pkg::CODE_ENABLE);

    always_comb begin
        st_nxt = st_r;
        if (bus.bus_req && bus.bus_we && is_cmd) begin
            st_nxt.code = bus.bus_wdata[fwg_pkg::CODE_LSB +: 4];
        end
        if (bus.bus_req && bus.bus_we && is_stby && bus.from_ram) begin
            st_nxt.stby = bus.bus_wdata[fwg_pkg::STBY_BIT];
        end
        // clears win: any of these drops the standby bit, but the array stays cut while low_power is high
        if (bus.bus_req && is_flash) begin
            st_nxt.stby = 1'b0;
        end
        if (bus.irq_take || bus.low_power) begin
            st_nxt.stby = 1'b0;
        end
        st_nxt.rdata = 8'h00;
        if (bus.bus_req && !bus.bus_we) begin
            if (is_cmd) begin
                // low nibble is don't-care; reads as zero here
                st_nxt.rdata = {st_r.code, 4'h0};
            end else if (is_stby) begin
                st_nxt.rdata = {7'h00, st_r.stby};
            end
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_b) begin
            st_r.code  <= fwg_pkg::CODE_RESET;
            st_r.stby  <= fwg_pkg::STBY_RESET;
            st_r.rdata <= 8'h00;
        end else begin
            st_r <= st_nxt;
        end
    end

    // a flash write during command mode is passed to the array only when enabled
    assign bus.cmd_fire   = bus.bus_req && bus.bus_we && is_flash && cmd_en;
    assign bus.bus_rdata  = st_r.rdata;
    assign bus.flash_stby = st_r.stby || bus.low_power;
    assign o_cmd_enabled  = cmd_en;
    assign o_array_powered = !(st_r.stby || bus.low_power);
endmodule

// [bench/fwg_monitor.sv]
`timescale 1ns/1ps
module fwg_monitor (
    // clock and reset
    input  wire logic        i_core_clk,
    input  wire logic        i_rst_b,
    // link signals
    input  wire logic        bus_req,
    input  wire logic        bus_we,
    input  wire logic [15:0] bus_addr,
    input  wire logic [7:0]  bus_wdata,
    input  wire logic        from_ram,
    input  wire logic        irq_take,
    input  wire logic        low_power,
    input  wire logic [7:0]  bus_rdata,
    input  wire logic        cmd_fire,
    input  wire logic        flash_stby
);
    logic [3:0] code_r;
    wire        wr = bus_req && bus_we;
    wire        fl = bus_addr >= fwg_pkg::FLASH_BASE;
    wire        sw = wr && bus_addr == fwg_pkg::STBY_CTRL_ADDR;
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (!i_rst_b);
    // shadow of the protection code, so fire decisions can be judged
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_b) begin
            code_r <= fwg_pkg::CODE_RESET;
        end else if (wr && bus_addr == fwg_pkg::CMD_CTRL_ADDR) begin
            code_r <= bus_wdata[fwg_pkg::CODE_LSB +: 4];
        end
    end
    a_fire_cause: assert property (cmd_fire |-> wr && fl && code_r == fwg_pkg::CODE_ENABLE)
        else $error("fire without enabled flash write");
    a_protect_blocks: assert property (wr && fl && code_r != fwg_pkg::CODE_ENABLE |-> !cmd_fire)
        else $error("fire while protected");
    a_enabled_fires: assert property (wr && fl && code_r == fwg_pkg::CODE_ENABLE |-> cmd_fire)
        else $error("enabled flash write gave no fire");
    a_flash_ignored: assert property (sw && !from_ram && !flash_stby |=> !flash_stby || low_power)
        else $error("standby set from flash code");
    a_lowpwr_cuts: assert property (low_power |-> flash_stby)
        else $error("low power left flash on");
    a_ram_sets: assert property (sw && bus_wdata[0] && from_ram && !irq_take |=> flash_stby)
        else $error("standby not set from ram");
    a_access_clears: assert property (bus_req && fl |=> !flash_stby || low_power)
        else $error("flash access kept standby");
    a_irq_clears: assert property (irq_take |=> !flash_stby || low_power)
        else $error("interrupt kept standby");
    a_lp_exit_clear: assert property ($fell(low_power) |-> !flash_stby)
        else $error("standby survived low power");
endmodule

// [bench/tb_flash_write_guard_and_standby.sv]
`timescale 1ns/1ps
module tb_flash_write_guard_and_standby;
    logic        i_core_clk = 0;
    logic        i_rst_b = 0;
    logic [3:0]  i_addr = 0;
    logic [7:0]  i_wdata = 0;
    logic        i_wr = 0;
    logic        i_rd = 1'b0;
    logic [7:0]  rdata;
    logic [7:0]  rd;
    logic        cmd_en;
    logic        pwr;
    logic [15:0] r = 16'ha6bd;
    logic [15:0] a;
    int          miscompares = 0;
    int          total_checks = 0;
    int          fires = 0;
    int          exp_f = 0;
    localparam logic [15:0] S = fwg_pkg::STBY_CTRL_ADDR;
    fwg_if bus ();
    fwg_device u_fwg_device (.i_core_clk(i_core_clk), .i_rst_b(i_rst_b), .bus(bus.dev), .o_cmd_enabled(cmd_en),
                             .o_array_powered(pwr));
    fwg_cpu u_fwg_cpu (.i_core_clk(i_core_clk), .i_rst_b(i_rst_b), .i_addr(i_addr), .i_wdata(i_wdata),
                       .i_wr(i_wr), .i_rd(i_rd), .o_rdata(rdata), .bus(bus.cpu));
    fwg_monitor u_mon (.i_core_clk(i_core_clk), .i_rst_b(i_rst_b), .bus_req(bus.bus_req), .bus_we(bus.bus_we),
        .bus_addr(bus.bus_addr), .bus_wdata(bus.bus_wdata), .from_ram(bus.from_ram), .irq_take(bus.irq_take),
        .low_power(bus.low_power), .bus_rdata(bus.bus_rdata), .cmd_fire(bus.cmd_fire), .flash_stby(bus.flash_stby));
    always #4 i_core_clk = ~i_core_clk;
    // an unknown fire counts as a fire, so it cannot slip through as a zero
    always @(posedge i_core_clk) if (i_rst_b && bus.cmd_fire !== 1'b0) fires++;
    function automatic logic [15:0] nx(logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    function automatic int ef(logic [15:0] ad, logic en);
        return int'(en && ad >= fwg_pkg::FLASH_BASE);
    endfunction
    task automatic w(logic [3:0] ad, logic [7:0] d);
        @(posedge i_core_clk);
        i_addr <= ad;
        i_wdata <= d;
        i_wr <= 1;
        @(posedge i_core_clk);
        i_wr <= 0;
    endtask
    // #1 lets the edge's updates land before anything is sampled
    task automatic idle();
        repeat (3) @(posedge i_core_clk);
        #1;
    endtask
    task automatic op(logic [15:0] ad, logic [7:0] d, logic [2:0] g);
        w(4'h0, ad[15:8]);
        w(4'h4, ad[7:0]);
        w(4'h1, d);
        w(4'h2, {5'h0, g});
        idle();
    endtask
    // read strobe for one cycle; the data stand only in the cycle after it
    task automatic rx(logic [3:0] ad, output logic [7:0] d);
        @(posedge i_core_clk);
        i_addr <= ad;
        i_rd <= 1'b1;
        @(posedge i_core_clk);
        i_rd <= 1'b0;
        #1;
        d = rdata;
    endtask
    task automatic chk(string n, logic [7:0] e, logic [7:0] g);
        total_checks++;
        if (g !== e) begin
            $display("[FAIL] %s expected %h seen %h", n, e, g);
            miscompares++;
        end
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    initial begin
        repeat (2) @(posedge i_core_clk);
        i_rst_b <= 1;
        idle();
        chk("cmd_en", 0, cmd_en);
        op(16'hc000, 8'h5a, 3'h3);
        chk("fires", 0, 8'(fires));
        for (int k = 0; k < 16; k++) begin
            r = nx(r);
            // enable/protect mix: undefined codes are never written
            op(fwg_pkg::CMD_CTRL_ADDR, {r[0] ? fwg_pkg::CODE_ENABLE : fwg_pkg::CODE_PROTECT, 4'h8}, 3'h3);
            chk("cmd_en", {7'h0, r[0]}, {7'h0, cmd_en});
            a = k < 2 ? (k ? 16'hbfff : 16'hffff) : {r[1] ? 2'b11 : 2'b10, r[15:2]};
            op(a, r[15:8], 3'h3);
            exp_f += ef(a, r[0]);
            chk("fires", 8'(exp_f), 8'(fires));
        end
        op(fwg_pkg::CMD_CTRL_ADDR, {fwg_pkg::CODE_PROTECT, 4'h8}, 3'h3);
        chk("cmd_en", 0, cmd_en);
        $display("test guard done");
        // code readback: only the upper nibble means anything
        op(fwg_pkg::CMD_CTRL_ADDR, 8'h00, 3'h2);
        rx(fwg_pkg::H_DATA, rd);
        chk("code_rd", {fwg_pkg::CODE_PROTECT, 4'h0}, {rd[7:4], 4'h0});
        op(fwg_pkg::CMD_CTRL_ADDR, {fwg_pkg::CODE_ENABLE, 4'h8}, 3'h3);
        op(fwg_pkg::CMD_CTRL_ADDR, 8'h00, 3'h2);
        rx(fwg_pkg::H_DATA, rd);
        chk("code_rd", {fwg_pkg::CODE_ENABLE, 4'h0}, {rd[7:4], 4'h0});
        // reset in mid-run must drop the enable code again
        @(posedge i_core_clk);
        i_rst_b <= 1'b0;
        repeat (2) @(posedge i_core_clk);
        i_rst_b <= 1'b1;
        idle();
        chk("cmd_en", 0, cmd_en);
        op(16'hc001, 8'h11, 3'h3);
        chk("fires", 8'(exp_f), 8'(fires));
        op(fwg_pkg::CMD_CTRL_ADDR, 8'h00, 3'h2);
        rx(fwg_pkg::H_DATA, rd);
        chk("code_rd", {fwg_pkg::CODE_RESET, 4'h0}, {rd[7:4], 4'h0});
        $display("test read done");
        op(S, 8'h01, 3'h1);
        chk("stby", 0, {7'h0, bus.flash_stby});
        op(S, 8'h01, 3'h3);
        chk("pwr", 0, {7'h0, pwr});
        rx(fwg_pkg::H_STATUS, rd);
        chk("status", 8'h01, rd);
        op(S, 8'h00, 3'h2);
        rx(fwg_pkg::H_DATA, rd);
        chk("stby_rd", 8'h01, rd);
        op(S, 8'h00, 3'h3);
        chk("pwr", 1, {7'h0, pwr});
        op(S, 8'h01, 3'h3);
        op(16'hc123, 8'h00, 3'h2);
        chk("stby", 0, {7'h0, bus.flash_stby});
        op(S, 8'h01, 3'h3);
        op(16'h0100, 8'h00, 3'h6);
        chk("stby", 0, {7'h0, bus.flash_stby});
        // set and interrupt in one cycle: the clear wins
        op(S, 8'h01, 3'h7);
        chk("stby", 0, {7'h0, bus.flash_stby});
        op(S, 8'h01, 3'h3);
        w(4'h5, 8'h01);
        idle();
        chk("stby", 1, {7'h0, bus.flash_stby});
        w(4'h5, 8'h00);
        idle();
        chk("pwr", 1, {7'h0, pwr});
        $display("test standby done");
        close_out();
    end
    initial begin
        repeat (20000) @(posedge i_core_clk);
        miscompares++;
        close_out();
    end
endmodule
